/* File: src/rso_read_sync.sv */
// Behaviour
// - After read gate and zero phase restart, clock output carries the oscillator.
// - With read gate low, clock output carries the reference clock.
// - Switching clock output source never produces a glitch.
// - Preamble found after 32 matching 1T/2T/3T pulses or 16 of 4T.
// - Preamble found stays latched until read gate drops.
// - Preamble found is zero whenever read gate is low.
// - Resynced data replicates media pulses, retimed to the oscillator clock.
// - Pump up flag high while comparator asks for upward correction.
// - Pump down flag high while comparator asks for downward correction.
// - Gain boost off low adds boost step; high uses nominal only.
// - Restart waits two oscillator cycles, pauses, aligns to second pulse.
// - No clock output pulse narrower than half a source period, except a high or the following low cut short by an early-pulse phase pull.
`timescale 1ns/1ns
`default_nettype none
module rso_read_sync #(
   parameter int FIFO_DEPTH = 8,
   parameter int DATA_W = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Read channel pins
   input wire logic read_window_ctl,
   input wire logic media_pulse_in,
   input wire logic ref_clk_in,
   input wire logic pattern_sel_lo,
   input wire logic pattern_sel_hi,
   input wire logic gain_boost_off,
   output logic recovered_clock_out,
   output logic resynced_data_out,
   output logic preamble_found,
   output logic phase_up_flag,
   output logic phase_down_flag,
   output logic [1:0] pump_current
);
   // Shifter needs two bits, read word needs at least one pad bit
   if (DATA_W < 2 || DATA_W > 31 || FIFO_DEPTH < 2) begin : bad_params
      $error("rso_read_sync: DATA_W must be 2..31, FIFO_DEPTH >= 2");
   end

   // ----------------------------------------------------------------
   // Read gate synchroniser and media pulse edge
   // ----------------------------------------------------------------
   logic rw_meta;
   logic rw_sync;
   logic mp_q;
   // Gate may move at any time, so two flops before use
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rw_meta <= 1'b0;
         rw_sync <= 1'b0;
         mp_q <= 1'b0;
      end else begin
         rw_meta <= read_window_ctl;
         rw_sync <= rw_meta;
         mp_q <= media_pulse_in;
      end
   end
   wire pulse = media_pulse_in && !mp_q;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] osc_half;
   logic ovfl;
   logic aw_got;
   logic w_got;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   rso_pkg::rso_status_s status;

   assign s_axi_awready = !aw_got && !s_axi_bvalid;
   assign s_axi_wready = !w_got && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire wr_have_a = aw_got || aw_take;
   wire wr_have_w = w_got || w_take;
   wire [3:0] wr_addr = aw_got ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_got ? w_data : s_axi_wdata;
   wire [3:0] wr_strb = w_got ? w_strb : s_axi_wstrb;
   wire wr_fire = wr_have_a && wr_have_w && !s_axi_bvalid;
   wire wr_ctrl = wr_fire && wr_addr == rso_pkg::REG_CTRL && wr_strb[0];
   wire wr_stat = wr_fire && wr_addr == rso_pkg::REG_STATUS && wr_strb[0];
   wire wr_known = wr_addr == rso_pkg::REG_CTRL || wr_addr == rso_pkg::REG_STATUS;
   wire [7:0] half_req = wr_data[rso_pkg::CTRL_HALF_LSB +: rso_pkg::CTRL_HALF_W];

   // Write address and data held separately, either may come first
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rso_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         aw_got <= wr_have_a && !wr_fire;
         w_got <= wr_have_w && !wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? rso_pkg::RESP_OKAY : rso_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Oscillator half period; too short a value would starve the comparator
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_half <= rso_pkg::OSC_HALF_RST;
      end else if (wr_ctrl) begin
         osc_half <= (half_req < rso_pkg::OSC_HALF_MIN) ? rso_pkg::OSC_HALF_MIN : half_req;
      end
   end

   // ----------------------------------------------------------------
   // Zero phase restart sequence
   // ----------------------------------------------------------------
   rso_pkg::rso_zps_e zstate;
   rso_pkg::rso_zps_e next_zstate;
   logic [1:0] zcnt;
   logic [7:0] osc_ph;
   wire [7:0] osc_end = 8'((osc_half << 1) - 8'h01);
   wire osc_tick = zstate != rso_pkg::ZS_PAUSE && osc_ph == osc_end;
   wire osc_lvl = osc_ph < osc_half;
   wire locked = zstate == rso_pkg::ZS_LOCK;

   always_comb begin
      next_zstate = zstate;
      case (zstate)
         rso_pkg::ZS_IDLE: if (rw_sync) next_zstate = rso_pkg::ZS_ARM;
         rso_pkg::ZS_ARM: if (osc_tick && zcnt == rso_pkg::ZPS_WAIT_TICKS - 2'h1) begin
            next_zstate = rso_pkg::ZS_PAUSE;
         end
         rso_pkg::ZS_PAUSE: if (pulse && zcnt == rso_pkg::ZPS_RESTART_PULSE - 2'h1) begin
            next_zstate = rso_pkg::ZS_LOCK;
         end
         rso_pkg::ZS_LOCK: next_zstate = zstate;
         default: next_zstate = rso_pkg::ZS_IDLE;
      endcase
      if (!rw_sync) begin
         next_zstate = rso_pkg::ZS_IDLE;
      end
   end

   // Counts oscillator ticks in arm, pulses in pause
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         zstate <= rso_pkg::ZS_IDLE;
         zcnt <= 2'h0;
      end else begin
         zstate <= next_zstate;
         if (next_zstate != zstate) begin
            zcnt <= 2'h0;
         end else if ((zstate == rso_pkg::ZS_ARM && osc_tick) || (zstate == rso_pkg::ZS_PAUSE && pulse)) begin
            zcnt <= zcnt + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Oscillator model and phase comparator
   // ----------------------------------------------------------------
   logic [7:0] dn_cnt;
   wire [1:0] gain_step = gain_boost_off ? rso_pkg::GAIN_NOMINAL
                                         : 2'(rso_pkg::GAIN_NOMINAL + rso_pkg::GAIN_BOOST);
   wire early = locked && pulse && osc_ph < osc_half;
   wire late = locked && pulse && osc_ph > osc_half;
   rso_pkg::rso_pump_s pump;

   assign pump_current = gain_step;

   // Nudge the phase by the current gain on each compared pulse, except a late one on the wrap tick
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_ph <= 8'h00;
      end else if (zstate == rso_pkg::ZS_PAUSE) begin
         osc_ph <= 8'h00;
      end else if (osc_tick) begin
         osc_ph <= 8'h00;
      end else if (early) begin
         osc_ph <= osc_ph + 8'h01 + 8'(gain_step);
      end else if (late) begin
         osc_ph <= osc_ph + 8'h01 - 8'(gain_step);
      end else begin
         osc_ph <= osc_ph + 8'h01;
      end
   end

   // Flag width follows the displacement from window centre
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pump <= '0;
         dn_cnt <= 8'h00;
      end else begin
         if (early) begin
            pump.up <= 1'b1;
         end else if (!locked || osc_ph >= osc_half) begin
            pump.up <= 1'b0;
         end
         if (late) begin
            dn_cnt <= 8'(osc_ph - osc_half);
            pump.down <= 1'b1;
         end else if (!locked || dn_cnt <= 8'h01) begin
            dn_cnt <= 8'h00;
            pump.down <= 1'b0;
         end else begin
            dn_cnt <= dn_cnt - 8'h01;
         end
      end
   end
   // Plain push-pull outputs; the far end may leave them open
   assign phase_up_flag = pump.up;
   assign phase_down_flag = pump.down;

   // ----------------------------------------------------------------
   // Preamble detector
   // ----------------------------------------------------------------
   logic [1:0] int_cnt;
   logic int_over;
   logic [5:0] match_cnt;
   wire [1:0] pat_sel = {pattern_sel_hi, pattern_sel_lo};
   wire [1:0] want_int = pat_sel;
   wire [5:0] need = (pat_sel == rso_pkg::PAT_4T) ? rso_pkg::PRE_NEED_LONG : rso_pkg::PRE_NEED_SHORT;
   wire match = pulse && !int_over && int_cnt == want_int;
   wire hit_last = locked && match && match_cnt == 6'(need - 6'h01);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_cnt <= 2'h0;
         int_over <= 1'b0;
         match_cnt <= 6'h00;
         preamble_found <= 1'b0;
      end else begin
         if (pulse || !locked) begin
            int_cnt <= 2'h0;
            int_over <= 1'b0;
         end else if (osc_tick) begin
            int_cnt <= int_cnt + 2'h1;
            int_over <= int_over || int_cnt == 2'h3;
         end
         if (!locked || (pulse && !match)) begin
            match_cnt <= 6'h00;
         end else if (match && match_cnt != need) begin
            match_cnt <= match_cnt + 6'h01;
         end
         if (!rw_sync) begin
            preamble_found <= 1'b0;
         end else if (hit_last) begin
            preamble_found <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Resynced data, deserialiser and buffer
   // ----------------------------------------------------------------
   logic seen;
   logic [DATA_W-1:0] shreg;
   logic [$clog2(DATA_W+1)-1:0] nbits;
   wire byte_full = nbits == ($clog2(DATA_W+1))'(DATA_W);
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [DATA_W-1:0] fifo_out_data;
   wire rd_data = ar_take && s_axi_araddr == rso_pkg::REG_DATA;

   // One bit per oscillator cycle: was there a media pulse in it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         seen <= 1'b0;
         resynced_data_out <= 1'b0;
      end else if (osc_tick) begin
         seen <= 1'b0; // A pulse on the tick belongs to the closing bit only
         resynced_data_out <= locked && (seen || pulse);
      end else begin
         seen <= seen || pulse;
      end
   end

   // Holds a full word while the buffer is full; bits meanwhile are lost
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shreg <= '0;
         nbits <= '0;
         ovfl <= 1'b0;
      end else begin
         if (byte_full && fifo_in_ready) begin
            nbits <= '0;
         end else if (locked && osc_tick && !byte_full) begin
            shreg <= {shreg[DATA_W-2:0], locked && (seen || pulse)};
            nbits <= nbits + 1'b1;
         end
         // Set wins over a same-cycle clear
         if (locked && osc_tick && byte_full && !fifo_in_ready) begin
            ovfl <= 1'b1;
         end else if (wr_stat && wr_data[rso_pkg::ST_OVFL]) begin
            ovfl <= 1'b0;
         end
      end
   end

   rso_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_data(shreg),
      .in_valid(byte_full),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(rd_data)
   );

   // ----------------------------------------------------------------
   // Clock output
   // ----------------------------------------------------------------
   wire src_osc;
   rso_clk_mux u_mux (
      .clk(clk),
      .sys_rst(sys_rst),
      .ref_lvl(ref_clk_in),
      .osc_lvl(osc_lvl),
      .want_osc(locked),
      .clk_out(recovered_clock_out),
      .src_osc(src_osc)
   );

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   assign status.found = preamble_found;
   assign status.lock = locked;
   assign status.src_osc = src_osc;
   assign status.fifo_ne = fifo_out_valid;
   assign status.ovfl = ovfl;
   wire [31:0] rd_mux = (s_axi_araddr == rso_pkg::REG_CTRL) ? {24'h0, osc_half} :
                        (s_axi_araddr == rso_pkg::REG_STATUS) ? {27'h0, status} :
                        {{(32-DATA_W){1'b0}}, fifo_out_data};
   wire rd_known = s_axi_araddr == rso_pkg::REG_CTRL || s_axi_araddr == rso_pkg::REG_STATUS ||
                   s_axi_araddr == rso_pkg::REG_DATA;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= rso_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_known ? rd_mux : 32'h0;
         s_axi_rresp <= rd_known ? rso_pkg::RESP_OKAY : rso_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   ref_source_a: assert property (@(posedge clk) disable iff (sys_rst)
      !rw_sync ##6 !rw_sync |-> !src_osc || !$past(src_osc, 6) || recovered_clock_out == 1'b0)
      else $error("reference not restored after gate drop");
   osc_source_a: assert property (@(posedge clk) disable iff (sys_rst)
      src_osc |-> $past(locked))
      else $error("oscillator selected outside lock");
   found_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      !rw_sync |=> !preamble_found)
      else $error("preamble flag set with gate low");
   found_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      preamble_found && rw_sync |=> preamble_found)
      else $error("preamble flag dropped early");
   found_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(preamble_found) |-> $past(match_cnt) == $past(need) - 6'h01 && $past(locked))
      else $error("preamble flag rose on wrong count");
   mismatch_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
      locked && pulse && !match |=> match_cnt == 6'h00)
      else $error("count kept after mismatch");
   zps_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
      zstate == rso_pkg::ZS_ARM && rw_sync && osc_tick && zcnt == 2'h1 |=> zstate == rso_pkg::ZS_PAUSE)
      else $error("pause not entered after two cycles");
   pump_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
      early |=> phase_up_flag ##1 !phase_down_flag [*2])
      else $error("pump flags wrong after early pulse");
   gain_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
      pump_current == (gain_boost_off ? 2'h1 : 2'h2))
      else $error("charge pump gain wrong");
   data_retime_a: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(resynced_data_out) |-> $past(osc_tick))
      else $error("data changed off the oscillator tick");

   lock_reach_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(locked));
   found_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(preamble_found));
   src_swap_c: cover property (@(posedge clk) disable iff (sys_rst) $fell(src_osc));
   fifo_full_c: cover property (@(posedge clk) disable iff (sys_rst) !fifo_in_ready);
endmodule : rso_read_sync
`default_nettype wire

/* File: src/rso_pkg.sv */
package rso_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;

   // Control field layout and reset values
   localparam int CTRL_HALF_LSB = 0;
   localparam int CTRL_HALF_W = 8;
   localparam logic [7:0] OSC_HALF_RST = 8'h04;
   localparam logic [7:0] OSC_HALF_MIN = 8'h04;

   // Status bit positions
   localparam int ST_FOUND = 0;
   localparam int ST_LOCK = 1;
   localparam int ST_SRC_OSC = 2;
   localparam int ST_FIFO_NE = 3;
   localparam int ST_OVFL = 4;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Timing and detector constants
   // ----------------------------------------------------------------
   localparam logic [1:0] ZPS_WAIT_TICKS = 2'h2;
   localparam logic [1:0] ZPS_RESTART_PULSE = 2'h2;
   localparam logic [5:0] PRE_NEED_SHORT = 6'h20;
   localparam logic [5:0] PRE_NEED_LONG = 6'h10;
   localparam logic [1:0] PAT_4T = 2'h3;
   localparam logic [1:0] GAIN_NOMINAL = 2'h1;
   localparam logic [1:0] GAIN_BOOST = 2'h1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ZS_IDLE, ZS_ARM, ZS_PAUSE, ZS_LOCK} rso_zps_e;

   typedef struct packed {
      logic up;
      logic down;
   } rso_pump_s;

   typedef struct packed {
      logic ovfl;
      logic fifo_ne;
      logic src_osc;
      logic lock;
      logic found;
   } rso_status_s;

endpackage : rso_pkg

/* File: src/rso_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module rso_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   // Refuse depths the pointer arithmetic cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : bad_params
      $error("rso_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Extra pointer bit tells full from empty
   assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Pointers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(push);
         rd_ptr <= rd_ptr + (AW+1)'(pop);
      end
   end

   // Storage, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   no_overrun_a: assert property (@(posedge clk) disable iff (sys_rst)
      !in_ready |=> wr_ptr == $past(wr_ptr))
      else $error("fifo written while full");
endmodule : rso_fifo
`default_nettype wire

/* File: src/rso_clk_mux.sv */
`timescale 1ns/1ns
`default_nettype none
module rso_clk_mux (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ref_lvl,
   input wire logic osc_lvl,
   input wire logic want_osc,
   output logic clk_out,
   output logic src_osc
);
   // Switch only while output and old source are low, then wait for a
   // falling edge of the new source: the low around the switch and the
   // next high both last a whole source half period, also after reset.
   logic armed;
   logic cur_q;
   wire cur_lvl = src_osc ? osc_lvl : ref_lvl;
   wire do_switch = (want_osc != src_osc) && !clk_out && !cur_lvl;
   wire cur_fell = cur_q && !cur_lvl;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         src_osc <= 1'b0;
         armed <= 1'b0;
         cur_q <= 1'b0;
         clk_out <= 1'b0;
      end else if (do_switch) begin
         src_osc <= want_osc;
         armed <= 1'b0;
         cur_q <= 1'b0;
         clk_out <= 1'b0;
      end else begin
         armed <= armed || cur_fell;
         cur_q <= cur_lvl;
         clk_out <= cur_lvl && armed;
      end
   end

   fall_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(clk_out) |-> !$past(cur_lvl) || $past(do_switch))
      else $error("clock output fell while its source was high");
   no_high_sw_a: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(src_osc) |-> !$past(clk_out))
      else $error("source switched during a high phase");
endmodule : rso_clk_mux
`default_nettype wire

/* File: tb/rso_media_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Pulse detector stand-in: one pulse per gap clocks, free-running reference
// Pump flags are not wired to this side, left open
module rso_media_model (
   input wire logic clk,
   input wire logic [7:0] gap,
   input wire logic run,
   output logic pulse,
   output logic ref_lvl
);
   logic [7:0] cnt = 8'h00;
   logic [3:0] rcnt = 4'h0;
   // Reference half period of 8 clocks, kept slow against clk
   always_ff @(posedge clk) begin
      cnt <= (!run || cnt == gap - 8'h01) ? 8'h00 : cnt + 8'h01;
      pulse <= run && cnt == 8'h00;
      rcnt <= rcnt + 4'h1;
      ref_lvl <= rcnt[3];
   end
endmodule : rso_media_model
`default_nettype wire

/* File: tb/read_sync_output_logic_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module read_sync_output_logic_tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic gate = 1'b0, run = 1'b0, sel_lo = 1'b0, sel_hi = 1'b0, boost_off = 1'b1, last = 1'b0;
   logic [3:0] awa = 4'h0, ara = 4'h0;
   logic [31:0] wd = 32'h0, rdat, d;
   logic [7:0] gap = 8'h08;
   logic [1:0] bresp, rresp, pump, r;
   logic awr, wrdy, bv, arr, rv, sck, sd, found, up, dn, pulse, refl;
   int failures = 0, compares = 0, run_len = 0, pact = 0, hits = 0, pull = 0;
   // 125 MHz clock
   always #4 clk = ~clk;
   rso_media_model media (.clk(clk), .gap(gap), .run(run), .pulse(pulse), .ref_lvl(refl));
   rso_read_sync #(.FIFO_DEPTH(8), .DATA_W(8)) uut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .read_window_ctl(gate), .media_pulse_in(pulse), .ref_clk_in(refl),
      .pattern_sel_lo(sel_lo), .pattern_sel_hi(sel_hi), .gain_boost_off(boost_off),
      .recovered_clock_out(sck), .resynced_data_out(sd), .preamble_found(found), .phase_up_flag(up),
      .phase_down_flag(dn), .pump_current(pump));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic report_and_stop;
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   // Bus cycles: ready and answer sampled mid-cycle, acted on at the edge
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      logic [1:0] s;
      @(posedge clk);
      {awa, wd, awv, wv, br} <= {a, v, 3'h7};
      do begin
         @(negedge clk);
         {ta, tw, tb, s} = {awr, wrdy, bv, bresp};
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end while (tb !== 1'b1);
      br <= 1'b0;
      chk("write resp", {30'h0, rso_pkg::RESP_OKAY}, {30'h0, s});
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] q, output logic [1:0] s);
      logic ta, t;
      @(posedge clk);
      {ara, arv, rr} <= {a, 2'h3};
      do begin
         @(negedge clk);
         {ta, t, q, s} = {arr, rv, rdat, rresp};
         @(posedge clk);
         if (ta) arv <= 1'b0;
      end while (t !== 1'b1);
      rr <= 1'b0;
   endtask : rd
   // Gate up and wait for the preamble flag, never before the count
   task automatic hunt(input logic [1:0] sel, input logic [7:0] g, input int need);
      int n;
      {sel_hi, sel_lo, gap, run, gate} <= {sel, g, 2'h3};
      repeat ((need - 2) * g) @(negedge clk);
      chk("found early", 32'h0, {31'h0, found});
      for (n = 0; found !== 1'b1 && n < 1000; n++) @(negedge clk);
      chk("found", 32'h1, {31'h0, found});
   endtask : hunt
   // Clock output levels never shorter than an oscillator half period;
   // the two levels around a comparator phase pull are not switch glitches
   always @(negedge clk) begin
      if (up) pact |= 1;
      if (dn) pact |= 2;
      if (up) pull = 2;
      if (sck !== last) begin
         if (run_len < 4 && pull == 0) chk("clock level width", 32'h4, run_len);
         if (pull > 0) pull--;
      end
      run_len = (sck !== last) ? 1 : run_len + 1;
      last = sck;
   end
   // Watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      rd(4'h0, d, r);
      chk("ctrl reset", 32'h4, d);
      rd(4'hc, d, r);
      chk("unmapped resp", {30'h0, rso_pkg::RESP_SLVERR}, {30'h0, r});
      chk("pump nominal", 32'h1, {30'h0, pump});
      boost_off <= 1'b0;
      @(negedge clk);
      chk("pump boosted", 32'h2, {30'h0, pump});
      wr(4'h0, 32'h1);
      rd(4'h0, d, r);
      chk("ctrl clamp", 32'h4, d);
      hunt(2'h0, 8'h08, 32);
      chk("data ones", 32'h1, {31'h0, sd});
      gap <= 8'h14; // Off-period pulses must not drop the flag
      repeat (900) @(negedge clk);
      chk("found held", 32'h1, {31'h0, found});
      rd(4'h4, d, r);
      chk("status locked", 32'h1f, d & 32'h1f);
      {gate, run} <= 2'h0;
      repeat (8) @(negedge clk);
      chk("found gate low", 32'h0, {31'h0, found});
      repeat (200) @(negedge clk);
      chk("data idle", 32'h0, {31'h0, sd});
      rd(4'h4, d, r);
      chk("source ref", 32'h0, d & 32'h7);
      repeat (9) begin
         rd(4'h8, d, r);
         if (d[7:0] === 8'hff) hits++;
      end
      chk("ones words", 32'h1, {31'h0, hits > 0});
      rd(4'h4, d, r);
      chk("drained", 32'h10, d & 32'h18);
      wr(4'h4, 32'h10);
      rd(4'h4, d, r);
      chk("ovfl cleared", 32'h0, d & 32'h10);
      hunt(2'h3, 8'h20, 16);
      chk("pump activity", 32'h3, pact);
      report_and_stop();
   end
endmodule : read_sync_output_logic_tb_top
`default_nettype wire
